// ==== bench/i2csam_assertions.sv ====
`timescale 1ns/100ps
module i2csam_checker (
  input wire logic                         pclk,
  input wire logic                         presetn,
  input wire logic                         psel,
  input wire logic                         penable,
  input wire logic                         pslverr,
  input wire logic                         master_mode,
  input wire logic                         addr_valid,
  input wire logic [7:0]                   addr_byte,
  input wire logic                         addr_match,
  input wire logic                         general_call,
  input wire logic [i2csam_pkg::SLOTS-1:0] match_slots,
  input wire logic [7:0]                   status_code
);
  import i2csam_pkg::*;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_master_ignored: assert property (addr_valid && master_mode |=> !addr_match)
    else $error("match while in master operation");
  a_match_cause: assert property (addr_match |-> $past(addr_valid) && !$past(master_mode))
    else $error("match without a slave address");
  a_gc_zero: assert property (general_call |-> addr_match && $past(addr_byte[7:1]) == 7'h00)
    else $error("general call on nonzero address");
  a_own_code: assert property (addr_match && !general_call |-> $past(addr_byte[7:1]) != 7'h00
    && status_code == ($past(addr_byte[0]) ? CODE_OWN_READ : CODE_OWN_WRITE))
    else $error("wrong own address status code");
  a_gc_code: assert property (general_call |-> status_code == CODE_GEN_CALL)
    else $error("wrong general call status code");
  a_slots_hit: assert property (addr_match |-> match_slots != '0)
    else $error("match with no slot");
  a_slots_hold: assert property (!addr_match |-> $stable(match_slots))
    else $error("slots changed without match");
  a_code_hold: assert property (!addr_match |-> $stable(status_code))
    else $error("status code changed without match");
  a_err_access: assert property (pslverr |-> psel && penable)
    else $error("error outside access cycle");
endmodule

// ==== bench/i2csam_far_master.sv ====
`timescale 1ns/100ps
module i2csam_far_master (
  input wire logic       pclk,
  output logic       addr_valid,
  output logic [7:0] addr_byte
);
  initial begin
    addr_valid = 1'b0;
    addr_byte  = 8'hFF;
  end
  // Released byte shows its inverse so a stale address never looks valid
  task automatic send(input logic [6:0] addr, input logic rw);
    @(posedge pclk);
    addr_valid <= 1'b1;
    addr_byte  <= {addr, rw};
    @(posedge pclk);
    addr_valid <= 1'b0;
    addr_byte  <= ~{addr, rw};
  endtask
endmodule

// ==== bench/tb_i2c_slave_address_matcher.sv ====
`timescale 1ns/100ps
module tb_i2c_slave_address_matcher;
  import i2csam_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, master_mode, pready, pslverr, errv;
  logic        addr_valid, addr_match, general_call, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [3:0]  pstrb, match_slots, exp_slots, strb_sel;
  logic [7:0]  addr_byte, status_code, exp_code;
  int          failures, check_count;
  i2csam_matcher dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .master_mode(master_mode), .addr_valid(addr_valid),
    .addr_byte(addr_byte), .addr_match(addr_match), .general_call(general_call),
    .match_slots(match_slots), .status_code(status_code), .irq(irq));
  i2csam_far_master far (.pclk(pclk), .addr_valid(addr_valid), .addr_byte(addr_byte));
  always #20 pclk = ~pclk;
  // ***************************************************
  // Bus and check tasks
  // ***************************************************
  task stop_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= strb_sel;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(posedge pclk);
    // Request stands until pready is seen high at a rising edge
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (pready !== 1'b1) begin
      failures++;
      stop_test;
    end
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    check("pready wait", n, 32'h0);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d, input logic ee);
    apb(1'b1, a, d);
    check("pslverr", {31'h0, errv}, {31'h0, ee});
  endtask
  task rd(input logic [11:0] a, input logic [31:0] exp, input logic ee);
    apb(1'b0, a, 32'h0);
    check("prdata", rdv, exp);
    check("pslverr", {31'h0, errv}, {31'h0, ee});
  endtask
  task addr(input logic [6:0] a, input logic r, input logic [3:0] sl);
    far.send(a, r);
    #1;
    check("addr_match", {31'h0, addr_match}, {31'h0, sl != 4'h0});
    check("general_call", {31'h0, general_call}, {31'h0, sl != 4'h0 && a == 7'h00});
    if (sl != 4'h0) begin
      exp_slots = sl;
      exp_code = (a == 7'h00) ? CODE_GEN_CALL : (r ? CODE_OWN_READ : CODE_OWN_WRITE);
    end
    check("match_slots", {28'h0, match_slots}, {28'h0, exp_slots});
    check("status_code", {24'h0, status_code}, {24'h0, exp_code});
  endtask
  // Interrupt level is looked at once the last write has settled
  task irq_is(input logic e);
    @(negedge pclk);
    check("irq", {31'h0, irq}, {31'h0, e});
  endtask
  // ***************************************************
  // Main sequence
  // ***************************************************
  initial begin
    {pclk, presetn, psel, penable, pwrite, master_mode} = 6'h00;
    {paddr, pwdata, pstrb} = {12'h000, 32'h0, 4'hF};
    strb_sel = 4'hF;
    {failures, check_count, exp_slots, exp_code} = {32'h0, 32'h0, 4'h0, CODE_IDLE};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < SLOTS; i++) begin
      rd(OWN_ADDR_OFFSET[i], 32'h0, 1'b0);
      rd(ADDR_MASK_OFFSET[i], 32'h0, 1'b0);
    end
    rd(12'h008, 32'h0, 1'b1);
    wr(MATCH_INFO_OFFSET, 32'h1, 1'b1);
    wr(OWN_ADDR_OFFSET[0], 32'h54, 1'b0);
    // A write without byte lane 0 leaves the slot alone
    strb_sel = 4'hE;
    wr(OWN_ADDR_OFFSET[0], 32'hAA, 1'b0);
    strb_sel = 4'hF;
    rd(OWN_ADDR_OFFSET[0], 32'h54, 1'b0);
    addr(7'h2A, 1'b0, 4'h0);
    wr(CTRL_OFFSET, 32'h1, 1'b0);
    wr(INT_MASK_OFFSET, 32'h3, 1'b0);
    wr(OWN_ADDR_OFFSET[1], 32'h20, 1'b0);
    wr(ADDR_MASK_OFFSET[1], 32'h1F, 1'b0);
    rd(ADDR_MASK_OFFSET[1], 32'h1E, 1'b0);
    wr(OWN_ADDR_OFFSET[2], 32'hFF, 1'b0);
    wr(OWN_ADDR_OFFSET[3], 32'h83, 1'b0);
    rd(OWN_ADDR_OFFSET[3], 32'h83, 1'b0);
    addr(7'h2A, 1'b0, 4'b0001);
    addr(7'h2A, 1'b1, 4'b0001);
    addr(7'h1B, 1'b0, 4'b0010);
    addr(7'h2B, 1'b0, 4'h0);
    addr(7'h00, 1'b0, 4'b1100);
    addr(7'h41, 1'b1, 4'b1000);
    irq_is(1'b1);
    rd(INT_STATUS_OFFSET, 32'h3, 1'b0);
    rd(MATCH_INFO_OFFSET, {12'h0, 4'b1000, 8'h83, CODE_OWN_READ}, 1'b0);
    wr(INT_MASK_OFFSET, 32'h2, 1'b0);
    wr(INT_STATUS_OFFSET, 32'h2, 1'b0);
    irq_is(1'b0);
    wr(INT_MASK_OFFSET, 32'h1, 1'b0);
    irq_is(1'b1);
    wr(INT_STATUS_OFFSET, 32'h1, 1'b0);
    irq_is(1'b0);
    wr(OWN_ADDR_OFFSET[2], 32'hFE, 1'b0);
    wr(OWN_ADDR_OFFSET[3], 32'h82, 1'b0);
    addr(7'h00, 1'b0, 4'h0);
    @(posedge pclk);
    master_mode <= 1'b1;
    addr(7'h2A, 1'b0, 4'h0);
    @(posedge pclk);
    master_mode <= 1'b0;
    // Reset in mid-run clears the slots and returns the status code to CODE_IDLE
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(OWN_ADDR_OFFSET[3], 32'h0, 1'b0);
    check("status_code", {24'h0, status_code}, {24'h0, CODE_IDLE});
    check("match_slots", {28'h0, match_slots}, 32'h0);
    stop_test;
  end
endmodule
bind i2csam_matcher i2csam_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pslverr(pslverr), .master_mode(master_mode), .addr_valid(addr_valid),
  .addr_byte(addr_byte), .addr_match(addr_match), .general_call(general_call),
  .match_slots(match_slots), .status_code(status_code));

// ==== logic/i2csam_matcher.sv ====
`timescale 1ns/100ps
module i2csam_matcher (
  input  wire logic                                pclk,
  input  wire logic                                presetn,
  input  wire logic                                psel,
  input  wire logic                                penable,
  input  wire logic                                pwrite,
  input  wire logic [i2csam_pkg::PADDR_W-1:0]      paddr,
  input  wire logic [31:0]                         pwdata,
  input  wire logic [3:0]                          pstrb,
  output logic                                     pready,
  output logic      [31:0]                         prdata,
  output logic                                     pslverr,
  input  wire logic                                master_mode,
  input  wire logic                                addr_valid,
  input  wire logic [7:0]                          addr_byte,
  output logic                                     addr_match,
  output logic                                     general_call,
  output logic      [i2csam_pkg::SLOTS-1:0]        match_slots,
  output logic      [7:0]                          status_code,
  output logic                                     irq
);
  import i2csam_pkg::*;

  // ***************************************************
  // State
  // ***************************************************
  i2csam_state_type state_reg;
  i2csam_state_type state_next;

  logic [SLOTS-1:0]  own_hit;
  logic [SLOTS-1:0]  gc_hit;
  logic [ADDR_W-1:0] rx_address;
  logic              rx_rw;
  logic              rx_zero;
  logic              setup_phase;
  logic              access_phase;
  logic              write_lane0;

  assign rx_address   = addr_byte[7:ADDR_LSB];
  assign rx_rw        = addr_byte[0];
  assign rx_zero      = (rx_address == 7'h00);
  assign setup_phase  = psel & ~penable;
  assign access_phase = psel & penable;
  assign write_lane0  = access_phase & pwrite & pstrb[0];

  // ***************************************************
  // Per-slot comparators
  // ***************************************************
  genvar gi;
  generate
    for (gi = 0; gi < SLOTS; gi++) begin : g_slot
      logic [ADDR_W-1:0] bit_ok;
      // Set mask bits force agreement, cleared ones need equal bits
      assign bit_ok = ~(rx_address ^ state_reg.own_address_field[gi])
                      | state_reg.address_mask_field[gi]; // see [RULE5] see [RULE6]
      // General-call address is reserved and never hits an own slot
      assign own_hit[gi] = ~rx_zero & (&bit_ok); // see [RULE2]
      assign gc_hit[gi]  = rx_zero & state_reg.general_call_enable[gi]; // see [RULE4] see [RULE9]
    end
  endgenerate

  // ***************************************************
  // Register read decode
  // ***************************************************
  function automatic logic [32:0] read_word(input i2csam_state_type s,
                                            input logic [PADDR_W-1:0] a);
    logic [32:0] r;
    r = {1'b1, 32'h0000_0000};
    for (int i = 0; i < SLOTS; i++) begin
      if (a == OWN_ADDR_OFFSET[i]) begin
        r = {1'b0, 24'h00_0000, s.own_address_field[i], s.general_call_enable[i]};
      end
      if (a == ADDR_MASK_OFFSET[i]) begin
        // Reserved mask bit 0 reads as zero
        r = {1'b0, 24'h00_0000, s.address_mask_field[i], 1'b0}; // see [RULE7]
      end
    end
    if (a == CTRL_OFFSET) begin
      r = {1'b0, 31'h0000_0000, s.slave_enable};
    end
    if (a == INT_STATUS_OFFSET) begin
      r = {1'b0, 30'h0000_0000, s.int_status};
    end
    if (a == INT_MASK_OFFSET) begin
      r = {1'b0, 30'h0000_0000, s.int_mask};
    end
    if (a == MATCH_INFO_OFFSET) begin
      r = {1'b0, 12'h000, s.match_slots, s.last_address, s.status_code};
    end
    return r;
  endfunction

  function automatic logic is_mapped_rw(input logic [PADDR_W-1:0] a);
    logic m;
    m = 1'b0;
    for (int i = 0; i < SLOTS; i++) begin
      if ((a == OWN_ADDR_OFFSET[i]) || (a == ADDR_MASK_OFFSET[i])) begin
        m = 1'b1;
      end
    end
    if ((a == CTRL_OFFSET) || (a == INT_STATUS_OFFSET) || (a == INT_MASK_OFFSET)) begin
      m = 1'b1;
    end
    return m;
  endfunction

  // ***************************************************
  // Next state
  // ***************************************************
  always_comb begin
    logic [32:0]      rd;
    logic [1:0]       ev_set;
    logic [1:0]       ev_clr;
    logic [SLOTS-1:0] hits;
    rd     = 33'h0_0000_0000;
    ev_set = 2'h0;
    ev_clr = 2'h0;
    hits   = own_hit | gc_hit;

    state_next              = state_reg;
    state_next.match_pulse  = 1'b0;
    state_next.general_call = 1'b0;

    // Address recognition, disabled while the controller is bus master
    if (addr_valid && !master_mode && state_reg.slave_enable) begin // see [RULE1]
      if (|hits) begin // see [RULE3]
        state_next.match_pulse  = 1'b1;
        state_next.match_slots  = hits;
        state_next.last_address = addr_byte;
        if (rx_zero) begin
          state_next.general_call = 1'b1;
          state_next.status_code  = CODE_GEN_CALL; // see [RULE8]
          ev_set[EV_GC_BIT]       = 1'b1;
        end else begin
          state_next.status_code  = rx_rw ? CODE_OWN_READ : CODE_OWN_WRITE; // see [RULE8]
          ev_set[EV_OWN_BIT]      = 1'b1;
        end
      end
    end

    // Read data and error are prepared in the setup cycle
    if (setup_phase) begin
      rd = read_word(state_reg, paddr);
      state_next.prdata  = pwrite ? 32'h0000_0000 : rd[31:0];
      state_next.pslverr = pwrite ? ~is_mapped_rw(paddr) : rd[32];
    end

    // Register writes take effect in the access cycle
    if (write_lane0) begin
      for (int i = 0; i < SLOTS; i++) begin
        if (paddr == OWN_ADDR_OFFSET[i]) begin
          state_next.own_address_field[i]   = pwdata[7:ADDR_LSB];
          state_next.general_call_enable[i] = pwdata[GC_BIT];
        end
        if (paddr == ADDR_MASK_OFFSET[i]) begin
          state_next.address_mask_field[i] = pwdata[7:ADDR_LSB];
        end
      end
      if (paddr == CTRL_OFFSET) begin
        state_next.slave_enable = pwdata[CTRL_ENABLE_BIT];
      end
      if (paddr == INT_STATUS_OFFSET) begin
        ev_clr = pwdata[1:0];
      end
      if (paddr == INT_MASK_OFFSET) begin
        state_next.int_mask = pwdata[1:0];
      end
    end

    // A new event wins over a simultaneous write-one clear
    state_next.int_status = (state_reg.int_status & ~ev_clr) | ev_set; // see [RULE8]
  end

  // ***************************************************
  // Registers
  // ***************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < SLOTS; i++) begin
        state_reg.own_address_field[i]   <= OWN_ADDR_RESET;
        state_reg.address_mask_field[i]  <= ADDR_MASK_RESET;
        state_reg.general_call_enable[i] <= GC_RESET;
      end
      state_reg.slave_enable <= ENABLE_RESET;
      state_reg.int_status   <= INT_RESET;
      state_reg.int_mask     <= INT_RESET;
      state_reg.status_code  <= CODE_IDLE;
      state_reg.last_address <= 8'h00;
      state_reg.match_slots  <= 4'h0;
      state_reg.match_pulse  <= 1'b0;
      state_reg.general_call <= 1'b0;
      state_reg.prdata       <= 32'h0000_0000;
      state_reg.pslverr      <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ***************************************************
  // Outputs
  // ***************************************************
  assign pready       = 1'b1;
  assign prdata       = state_reg.prdata;
  assign pslverr      = state_reg.pslverr & access_phase;
  assign addr_match   = state_reg.match_pulse;
  assign general_call = state_reg.general_call;
  assign match_slots  = state_reg.match_slots;
  assign status_code  = state_reg.status_code;
  assign irq          = |(state_reg.int_status & state_reg.int_mask);

endmodule

// ==== logic/i2csam_pkg.sv ====
// Behaviour
// [RULE1] In master operation the own-address slots are ignored and never match.
// [RULE2] Slot bits 7 to 1 hold the seven-bit own address compared with received bits.
// [RULE3] Respond as addressed slave when any of the four slots matches after masking.
// [RULE4] Slot bit 0 enables general-call recognition for that slot.
// [RULE5] A mask bit set to one makes that received address bit don't-care.
// [RULE6] A mask bit at zero requires the received bit to equal the stored bit.
// [RULE7] Four independent address and mask slot pairs; mask bit 0 is reserved.
// [RULE8] On being addressed, set the interrupt flag and load the status code.
// [RULE9] All-zero address matches only through a slot whose general-call enable is set.
package i2csam_pkg;

  localparam int unsigned SLOTS            = 4;
  localparam int unsigned ADDR_W           = 7;
  localparam int unsigned PADDR_W          = 12;

  // ***************************************************
  // Register offsets
  // ***************************************************
  localparam logic [SLOTS-1:0][PADDR_W-1:0] OWN_ADDR_OFFSET  =
    {12'h020, 12'h01C, 12'h018, 12'h004};
  localparam logic [SLOTS-1:0][PADDR_W-1:0] ADDR_MASK_OFFSET =
    {12'h030, 12'h02C, 12'h028, 12'h024};
  localparam logic [PADDR_W-1:0] CTRL_OFFSET       = 12'h034;
  localparam logic [PADDR_W-1:0] INT_STATUS_OFFSET = 12'h038;
  localparam logic [PADDR_W-1:0] INT_MASK_OFFSET   = 12'h044;
  localparam logic [PADDR_W-1:0] MATCH_INFO_OFFSET = 12'h048;

  // ***************************************************
  // Field positions
  // ***************************************************
  localparam int unsigned GC_BIT          = 0;
  localparam int unsigned ADDR_LSB        = 1;
  localparam int unsigned CTRL_ENABLE_BIT = 0;
  localparam int unsigned EV_OWN_BIT      = 0;
  localparam int unsigned EV_GC_BIT       = 1;
  localparam int unsigned INFO_CODE_LSB   = 0;
  localparam int unsigned INFO_ADDR_LSB   = 8;
  localparam int unsigned INFO_SLOT_LSB   = 16;

  // ***************************************************
  // Reset values and status codes
  // ***************************************************
  localparam logic [ADDR_W-1:0] OWN_ADDR_RESET  = 7'h00;
  localparam logic [ADDR_W-1:0] ADDR_MASK_RESET = 7'h00;
  localparam logic              GC_RESET        = 1'b0;
  localparam logic              ENABLE_RESET    = 1'b0;
  localparam logic [1:0]        INT_RESET       = 2'h0;
  localparam logic [7:0]        CODE_IDLE       = 8'hF8;
  localparam logic [7:0]        CODE_OWN_WRITE  = 8'h60;
  localparam logic [7:0]        CODE_OWN_READ   = 8'hA8;
  localparam logic [7:0]        CODE_GEN_CALL   = 8'h70;

  typedef struct packed {
    logic [SLOTS-1:0][ADDR_W-1:0] own_address_field;
    logic [SLOTS-1:0]             general_call_enable;
    logic [SLOTS-1:0][ADDR_W-1:0] address_mask_field;
    logic                         slave_enable;
    logic [1:0]                   int_status;
    logic [1:0]                   int_mask;
    logic [7:0]                   status_code;
    logic [7:0]                   last_address;
    logic [SLOTS-1:0]             match_slots;
    logic                         match_pulse;
    logic                         general_call;
    logic [31:0]                  prdata;
    logic                         pslverr;
  } i2csam_state_type;

endpackage
